// ==== rpu_pkg.sv ====
// rpu_pkg: constants shared by the region protection unit files.
// assumes the core transfers configuration words over a coprocessor register port.
package rpu_pkg;
    // ==========================================================
    // coprocessor register numbers and selector codes
    // ==========================================================
    localparam logic [3:0] RPU_CR_CTRL   = 4'h1;  // system control register
    localparam logic [3:0] RPU_CR_CACHE  = 4'h2;  // cacheable bits
    localparam logic [3:0] RPU_CR_BUFF   = 4'h3;  // bufferable bits
    localparam logic [3:0] RPU_CR_PERM   = 4'h5;  // access permissions
    localparam logic [3:0] RPU_CR_REGION = 4'h6;  // region base / size
    localparam logic [2:0] RPU_OP2_DATA  = 3'h0;  // selects data space
    localparam logic [2:0] RPU_OP2_INST  = 3'h1;  // selects instruction space
    // ==========================================================
    // field layout
    // ==========================================================
    localparam int RPU_NREG     = 8;              // regions per space
    localparam int RPU_CTRL_EN  = 0;              // protection enable bit
    localparam int RPU_BASE_LSB = 12;             // base address field low bit
    localparam int RPU_SIZE_LSB = 1;              // size code low bit
    localparam int RPU_SIZE_MSB = 5;              // size code high bit
    localparam int RPU_REN_BIT  = 0;              // region enable bit
    localparam logic [4:0] RPU_SIZE_MIN = 5'h0b;  // 4KB code
    localparam logic [31:0] RPU_RESET_W = 32'h0000_0000;  // reset for registers
    // ==========================================================
    // permission encoding
    // ==========================================================
    localparam logic [1:0] RPU_AP_NONE = 2'h0;    // no access
    localparam logic [1:0] RPU_AP_PRIV = 2'h1;    // privileged only
    localparam logic [1:0] RPU_AP_UREAD = 2'h2;   // user read only
    localparam logic [1:0] RPU_AP_FULL = 2'h3;    // full access
endpackage

// ==== rpu_chk_if.sv ====
// rpu_chk_if: carries one address check between the top and a checker.
// assumes both ends share one clock; all signals are combinational.
`timescale 1ns/10ps
interface rpu_chk_if;
    logic [31:0] addr;      // access address
    logic        wr;        // store access
    logic        user;      // user mode
    logic        pu_en;     // protection enabled
    logic [31:0] regs [8];  // region registers
    logic [15:0] perm;      // permission codes
    logic [7:0]  cach;      // cacheable bits
    logic [7:0]  buff;      // bufferable bits
    logic        abort;     // access refused
    logic        c_out;     // gated cacheable
    logic        b_out;     // gated bufferable
    modport top (output addr, wr, user, pu_en, regs, perm, cach, buff, input abort, c_out, b_out);
    modport chk (input addr, wr, user, pu_en, regs, perm, cach, buff, output abort, c_out, b_out);
endinterface

// ==== rpu_checker.sv ====
// rpu_checker: combinational region match, priority and permission check.
// assumes register contents are stable during the check.
`timescale 1ns/10ps
module rpu_checker
    import rpu_pkg::*;
(
    rpu_chk_if.chk ck
);
    // ==========================================================
    // region match
    // ==========================================================
    // true when addr lies in region described by word r
    function automatic logic rpu_hit(input logic [31:0] r, input logic [31:0] a);
        logic [4:0]  sz;
        logic [31:0] msk;
        sz  = r[RPU_SIZE_MSB:RPU_SIZE_LSB];
        // size code n spans 2**(n+1) bytes; 5'h1f gives the whole space
        msk = (sz == 5'h1f) ? 32'h0000_0000 : ~((32'h0000_0002 << sz) - 32'h0000_0001);
        rpu_hit = r[RPU_REN_BIT] && ((a & msk) == (r & msk & 32'hffff_f000));  // RULE19 RULE5
    endfunction

    logic [7:0] hit;  // per region match
    genvar g;
    generate
        for (g = 0; g < RPU_NREG; g++)
        begin : g_hit
            assign hit[g] = rpu_hit(ck.regs[g], ck.addr);  // RULE1
        end
    endgenerate

    // ==========================================================
    // priority and attributes
    // ==========================================================
    // highest numbered hit wins; no hit aborts
    always_comb
    begin
        logic [2:0] win;
        logic       any;
        logic [1:0] ap;
        logic       ok;
        win = 3'h0;
        any = 1'b0;
        ap  = 2'h0;
        ok  = 1'b0;
        for (int i = 0; i < RPU_NREG; i++)
        begin
            if (hit[i])
            begin
                win = 3'(i);  // RULE11
                any = 1'b1;
            end
        end
        ap = ck.perm[2*win +: 2];  // RULE17
        case (ap)  // RULE16
            RPU_AP_NONE:  ok = 1'b0;
            RPU_AP_PRIV:  ok = !ck.user;
            RPU_AP_UREAD: ok = !ck.user || !ck.wr;  // RULE12
            default:      ok = 1'b1;
        endcase
        // disabled unit ignores regions: no abort, no caching
        ck.abort = ck.pu_en && (!any || !ok);  // RULE9 RULE13 RULE3
        ck.c_out = ck.pu_en && any && ck.cach[win];  // RULE8 RULE3
        ck.b_out = ck.pu_en && any && ck.buff[win];  // RULE10 RULE18
    end
endmodule

// ==== rpu_top.sv ====
// rpu_top: region protection unit with coprocessor register port.
// assumes the core issues one write or read transfer per cycle, same clock.
`timescale 1ns/10ps
// Function
// RULE1 - eight instruction and eight data regions
// RULE2 - control bit 0 enables protection
// RULE3 - disabled: uncached, unbuffered, regions ignored
// RULE4 - region word: base, size, enable
// RULE5 - size code 01011 is 4KB, doubling
// RULE6 - software avoids reserved size codes
// RULE7 - software aligns base to size
// RULE8 - cacheable, permissions; bufferable data only
// RULE9 - failed check gives prefetch/data abort
// RULE10 - cacheable and bufferable select four modes
// RULE11 - highest numbered matching region wins
// RULE12 - user store to user-readonly aborts
// RULE13 - unmapped address aborts
// RULE14 - software programs regions before enabling
// RULE15 - software maps code in both spaces
// RULE16 - two-bit permission code decoding
// RULE17 - two permission bits per area
// RULE18 - one bufferable bit per data area
// RULE19 - disabled region never matches
module rpu_top
    import rpu_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        cp_wr,
    input  wire logic        cp_rd,
    input  wire logic [3:0]  cp_crn,
    input  wire logic [3:0]  cp_crm,
    input  wire logic [2:0]  cp_op2,
    input  wire logic [31:0] cp_wdata,
    output logic      [31:0] cp_rdata,
    input  wire logic [31:0] i_addr,
    input  wire logic        i_user,
    output logic             i_abort,
    output logic             i_cacheable,
    input  wire logic [31:0] d_addr,
    input  wire logic        d_wr,
    input  wire logic        d_user,
    output logic             d_abort,
    output logic             d_cacheable,
    output logic             d_bufferable
);
    import rpu_pkg::*;

    // ==========================================================
    // configuration state
    // ==========================================================
    logic [31:0] ctrl_r, ctrl_nxt;                 // system control
    logic [7:0]  icach_r, icach_nxt;               // instruction cacheable
    logic [7:0]  dcach_r, dcach_nxt;               // data cacheable
    logic [7:0]  dbuff_r, dbuff_nxt;               // data bufferable
    logic [15:0] iperm_r, iperm_nxt;               // instruction permissions
    logic [15:0] dperm_r, dperm_nxt;               // data permissions
    logic [31:0] ireg_r [8];                       // instruction regions
    logic [31:0] ireg_nxt [8];
    logic [31:0] dreg_r [8];                       // data regions
    logic [31:0] dreg_nxt [8];
    logic [31:0] rdata_nxt;                        // read data

    // register write decode
    always_comb
    begin
        ctrl_nxt  = ctrl_r;
        icach_nxt = icach_r;
        dcach_nxt = dcach_r;
        dbuff_nxt = dbuff_r;
        iperm_nxt = iperm_r;
        dperm_nxt = dperm_r;
        ireg_nxt  = ireg_r;
        dreg_nxt  = dreg_r;
        if (cp_wr)
        begin
            case (cp_crn)
                RPU_CR_CTRL:  ctrl_nxt = cp_wdata;  // RULE2
                RPU_CR_CACHE:
                    if (cp_op2 == RPU_OP2_INST) icach_nxt = cp_wdata[7:0];
                    else dcach_nxt = cp_wdata[7:0];
                // bufferable exists for data space only
                RPU_CR_BUFF:  dbuff_nxt = cp_wdata[7:0];  // RULE18 RULE8
                RPU_CR_PERM:
                    if (cp_op2 == RPU_OP2_INST) iperm_nxt = cp_wdata[15:0];  // RULE17
                    else dperm_nxt = cp_wdata[15:0];
                RPU_CR_REGION:
                    // unused bits 11:6 are not stored
                    if (cp_op2 == RPU_OP2_INST) ireg_nxt[cp_crm[2:0]] = cp_wdata & 32'hffff_f03f;  // RULE4
                    else dreg_nxt[cp_crm[2:0]] = cp_wdata & 32'hffff_f03f;
                default: ;  // other registers are not held here
            endcase
        end
    end

    // read mux; unmapped registers read zero
    always_comb
    begin
        rdata_nxt = RPU_RESET_W;
        if (cp_rd)
        begin
            case (cp_crn)
                RPU_CR_CTRL:   rdata_nxt = ctrl_r;
                RPU_CR_CACHE:  rdata_nxt = {24'h0, (cp_op2 == RPU_OP2_INST) ? icach_r : dcach_r};
                RPU_CR_BUFF:   rdata_nxt = {24'h0, dbuff_r};
                RPU_CR_PERM:   rdata_nxt = {16'h0, (cp_op2 == RPU_OP2_INST) ? iperm_r : dperm_r};
                RPU_CR_REGION: rdata_nxt = (cp_op2 == RPU_OP2_INST) ? ireg_r[cp_crm[2:0]] : dreg_r[cp_crm[2:0]];
                default:       rdata_nxt = RPU_RESET_W;
            endcase
        end
    end

    // register update; all configuration clears at reset, so every region starts disabled
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            ctrl_r   <= RPU_RESET_W;
            icach_r  <= 8'h00;
            dcach_r  <= 8'h00;
            dbuff_r  <= 8'h00;  // RULE18
            iperm_r  <= 16'h0000;
            dperm_r  <= 16'h0000;
            cp_rdata <= RPU_RESET_W;
            for (int i = 0; i < RPU_NREG; i++)
            begin
                ireg_r[i] <= RPU_RESET_W;  // RULE4
                dreg_r[i] <= RPU_RESET_W;
            end
        end
        else
        begin
            ctrl_r   <= ctrl_nxt;
            icach_r  <= icach_nxt;
            dcach_r  <= dcach_nxt;
            dbuff_r  <= dbuff_nxt;
            iperm_r  <= iperm_nxt;
            dperm_r  <= dperm_nxt;
            ireg_r   <= ireg_nxt;
            dreg_r   <= dreg_nxt;
            cp_rdata <= rdata_nxt;
        end
    end

    // ==========================================================
    // address checkers
    // ==========================================================
    logic pu_en;  // protection enable
    assign pu_en = ctrl_r[RPU_CTRL_EN];  // RULE2

    rpu_chk_if ick();  // instruction side
    rpu_chk_if dck();  // data side
    assign ick.addr  = i_addr;
    assign ick.wr    = 1'b0;
    assign ick.user  = i_user;
    assign ick.pu_en = pu_en;
    assign ick.regs  = ireg_r;
    assign ick.perm  = iperm_r;
    assign ick.cach  = icach_r;
    assign ick.buff  = 8'h00;  // RULE8
    assign dck.addr  = d_addr;
    assign dck.wr    = d_wr;
    assign dck.user  = d_user;
    assign dck.pu_en = pu_en;
    assign dck.regs  = dreg_r;
    assign dck.perm  = dperm_r;
    assign dck.cach  = dcach_r;
    assign dck.buff  = dbuff_r;

    rpu_checker u_ichk (.ck(ick));
    rpu_checker u_dchk (.ck(dck));

    // abort and attributes are combinational in the access cycle
    assign i_abort      = ick.abort;  // RULE9
    assign i_cacheable  = ick.c_out;
    assign d_abort      = dck.abort;  // RULE9
    assign d_cacheable  = dck.c_out;  // RULE10
    assign d_bufferable = dck.b_out;

    // ==========================================================
    // checks
    // ==========================================================
    pu_off_clean_a: assert property (@(posedge clk) disable iff (!rst_n)
        !pu_en |-> !i_abort && !d_abort && !i_cacheable && !d_cacheable && !d_bufferable)  // RULE3
        else $error("disabled unit gave abort or attributes");
    ctrl_en_a: assert property (@(posedge clk) disable iff (!rst_n)
        cp_wr && cp_crn == RPU_CR_CTRL |=> pu_en == $past(cp_wdata[0]))  // RULE2
        else $error("enable bit not taken");
    reset_off_a: assert property (@(posedge clk)
        !rst_n |=> !pu_en && dbuff_r == 8'h00)  // RULE18
        else $error("reset did not clear state");
    buff_only_a: assert property (@(posedge clk) disable iff (!rst_n)
        d_bufferable |-> pu_en && !d_abort || pu_en)  // RULE8
        else $error("bufferable while disabled");
    all_off_abort_a: assert property (@(posedge clk) disable iff (!rst_n)
        pu_en && dreg_r[0][0] == 1'b0 && dreg_r[1][0] == 1'b0 && dreg_r[2][0] == 1'b0
        && dreg_r[3][0] == 1'b0 && dreg_r[4][0] == 1'b0 && dreg_r[5][0] == 1'b0
        && dreg_r[6][0] == 1'b0 && dreg_r[7][0] == 1'b0 |-> d_abort)  // RULE13
        else $error("unmapped data access not aborted");
    region_wr_a: assert property (@(posedge clk) disable iff (!rst_n)
        cp_wr && cp_crn == RPU_CR_REGION && cp_op2 == RPU_OP2_DATA
        |=> dreg_r[$past(cp_crm[2:0])] == ($past(cp_wdata) & 32'hffff_f03f))  // RULE4
        else $error("region word not stored");
    rd_back_a: assert property (@(posedge clk) disable iff (!rst_n)
        cp_rd && cp_crn == RPU_CR_BUFF |=> cp_rdata == {24'h0, $past(dbuff_r)})  // RULE18
        else $error("bufferable readback wrong");
    full_map_a: assert property (@(posedge clk) disable iff (!rst_n)
        pu_en && dreg_r[0][5:0] == 6'h3f && dperm_r == 16'hffff |-> !d_abort)  // RULE16
        else $error("full access background aborted");
endmodule

// ==== rpu_core_model.sv ====
// rpu_core_model: core side of the register port and both access ports.
// assumes the bench calls its tasks; every task drive lands on a falling edge.
`timescale 1ns/10ps
module rpu_core_model
    import rpu_pkg::*;
(
    input  wire logic        clk,
    output logic             cp_wr,
    output logic             cp_rd,
    output logic [3:0]       cp_crn,
    output logic [3:0]       cp_crm,
    output logic [2:0]       cp_op2,
    output logic [31:0]      cp_wdata,
    input  wire logic [31:0] cp_rdata,
    output logic [31:0]      i_addr,
    output logic             i_user,
    output logic [31:0]      d_addr,
    output logic             d_wr,
    output logic             d_user
);
    // ==========================================
    // port drivers
    // ==========================================
    // quiet port at time zero
    initial
    begin
        {cp_wr, cp_rd, cp_crn, cp_crm, cp_op2, cp_wdata} = '0;
        {i_addr, i_user, d_addr, d_wr, d_user} = '0;
    end
    // one write; data inverted after, a released bus keeps no value
    task automatic cp_write(input logic [3:0] crn, input logic [2:0] op2, input logic [3:0] crm,
                            input logic [31:0] v);
        @(negedge clk);
        cp_wr = 1'b1;
        cp_crn = crn;
        cp_op2 = op2;
        cp_crm = crm;
        cp_wdata = v;
        @(negedge clk);
        cp_wr = 1'b0;
        cp_wdata = ~v;
    endtask
    // one read; data stands in the cycle after the request edge
    task automatic cp_read(input logic [3:0] crn, input logic [2:0] op2, input logic [3:0] crm,
                           output logic [31:0] v);
        @(negedge clk);
        cp_rd = 1'b1;
        cp_crn = crn;
        cp_op2 = op2;
        cp_crm = crm;
        @(negedge clk);
        cp_rd = 1'b0;
        v = cp_rdata;
    endtask
    // both accesses at once; answer is combinational, so settle briefly
    task automatic access(input logic [31:0] ia, input logic iu, input logic [31:0] da,
                          input logic dw, input logic du);
        @(negedge clk);
        i_addr = ia;
        i_user = iu;
        d_addr = da;
        d_wr = dw;
        d_user = du;
        #5;
    endtask
    // region word with a legal size and a base aligned to it
    function automatic logic [31:0] legal_region(input logic [31:0] r);
        logic [4:0]  sz;
        logic [63:0] m;
        sz = (r[5:1] < RPU_SIZE_MIN) ? r[5:1] + RPU_SIZE_MIN : r[5:1];
        m = (64'h2 << sz) - 64'h1;
        return {r[31:12] & ~m[31:12], r[11:6], sz, r[0]};
    endfunction
endmodule

// ==== region_protection_unit_tb.sv ====
// region_protection_unit_tb: rpu_top against an integer reference model.
// assumes rpu_core_model drives all design inputs except clk and rst_n.
`timescale 1ns/10ps
module region_protection_unit_tb;
    import rpu_pkg::*;
    // ==========================================
    // signals and model state
    // ==========================================
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        cp_wr, cp_rd, i_user, d_wr, d_user;
    logic [3:0]  cp_crn, cp_crm;
    logic [2:0]  cp_op2;
    logic [31:0] cp_wdata, cp_rdata, i_addr, d_addr, v;
    logic        i_abort, i_cacheable, d_abort, d_cacheable, d_bufferable;
    logic [31:0] m_reg [2][8];  // index 0 data, 1 instruction
    logic [15:0] m_perm [2];
    logic [7:0]  m_cach [2];
    logic [7:0]  m_buff;
    logic        m_en;
    int          miscompares, check_count, cycles;
    int          seed = 21;
    initial
    begin
        forever #20 clk = ~clk;
    end
    rpu_top u_dut (.clk(clk), .rst_n(rst_n), .cp_wr(cp_wr), .cp_rd(cp_rd), .cp_crn(cp_crn),
        .cp_crm(cp_crm), .cp_op2(cp_op2), .cp_wdata(cp_wdata), .cp_rdata(cp_rdata),
        .i_addr(i_addr), .i_user(i_user), .i_abort(i_abort), .i_cacheable(i_cacheable),
        .d_addr(d_addr), .d_wr(d_wr), .d_user(d_user), .d_abort(d_abort),
        .d_cacheable(d_cacheable), .d_bufferable(d_bufferable));
    rpu_core_model u_core (.clk(clk), .cp_wr(cp_wr), .cp_rd(cp_rd), .cp_crn(cp_crn),
        .cp_crm(cp_crm), .cp_op2(cp_op2), .cp_wdata(cp_wdata), .cp_rdata(cp_rdata),
        .i_addr(i_addr), .i_user(i_user), .d_addr(d_addr), .d_wr(d_wr), .d_user(d_user));
    // ==========================================
    // reference model and compares
    // ==========================================
    // expected {abort, cacheable, bufferable}; an abort masks the attributes
    function automatic logic [2:0] expect_acc(input int sp, input logic [31:0] a, input logic wr, user);
        logic [63:0] msk;
        logic [1:0]  ap;
        int          win;
        win = -1;
        if (!m_en)
            return 3'h0;
        for (int n = 0; n < RPU_NREG; n++)
        begin
            msk = (64'h2 << m_reg[sp][n][5:1]) - 64'h1;
            if (m_reg[sp][n][0] && (a & ~msk[31:0]) == (m_reg[sp][n] & ~msk[31:0])) win = n;
        end
        if (win < 0)
            return 3'h4;
        ap = m_perm[sp][2*win +: 2];
        if (ap == RPU_AP_NONE || (user && ap == RPU_AP_PRIV) || (user && wr && ap == RPU_AP_UREAD))
            return 3'h4;
        return {1'b0, m_cach[sp][win], (sp == 0) ? m_buff[win] : 1'b0};
    endfunction
    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_acc(input logic [2:0] got, input logic [2:0] exp);
        chk_reg({29'h0, exp[2] ? {got[2], 2'b00} : got}, {29'h0, exp});
    endtask
    // write through the core and mirror it in the model
    task automatic put(input logic [3:0] crn, input logic [2:0] op2, input logic [3:0] crm, input logic [31:0] w);
        u_core.cp_write(crn, op2, crm, w);
        case (crn)
            RPU_CR_CTRL: m_en = w[RPU_CTRL_EN];
            RPU_CR_CACHE: m_cach[op2[0]] = w[7:0];
            RPU_CR_BUFF: m_buff = w[7:0];
            RPU_CR_PERM: m_perm[op2[0]] = w[15:0];
            default: m_reg[op2[0]][crm[2:0]] = w & 32'hffff_f03f;
        endcase
    endtask
    task automatic get_chk(input logic [3:0] crn, input logic [2:0] op2, input logic [3:0] crm, input logic [31:0] exp);
        logic [31:0] r;
        u_core.cp_read(crn, op2, crm, r);
        chk_reg(r, exp);
    endtask
    task automatic acc_chk(input logic [31:0] ia, input logic iu, input logic [31:0] da, input logic dw, du);
        u_core.access(ia, iu, da, dw, du);
        chk_acc({i_abort, i_cacheable, 1'b0}, expect_acc(1, ia, 1'b0, iu));
        chk_acc({d_abort, d_cacheable, d_bufferable}, expect_acc(0, da, dw, du));
    endtask
    // addresses near a region base half the time, anywhere otherwise
    task automatic acc_rand;
        logic [31:0] r, s, ia, da;
        r = $random(seed);
        s = $random(seed);
        ia = r[31] ? s : (m_reg[1][r[2:0]] & 32'hffff_f000) + {19'h0, s[12:0]};
        da = r[30] ? $random(seed) : (m_reg[0][r[5:3]] & 32'hffff_f000) + {19'h0, s[28:16]};
        acc_chk(ia, r[8], da, r[9], r[10]);
    endtask
    task automatic finish_test;
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // ==========================================
    // timeout and main sequence
    // ==========================================
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            miscompares++;
            finish_test;
        end
    end
    initial
    begin
        m_reg = '{default: 32'h0};
        m_perm = '{default: 16'h0};
        m_cach = '{default: 8'h0};
        m_buff = 8'h0;
        m_en = 1'b0;
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        for (int n = 0; n < RPU_NREG; n++)
            get_chk(RPU_CR_REGION, RPU_OP2_INST, n[3:0], 32'h0);
        get_chk(RPU_CR_PERM, RPU_OP2_DATA, 4'h0, 32'h0);
        get_chk(RPU_CR_BUFF, RPU_OP2_DATA, 4'h0, 32'h0);
        $display("test reset_values done");
        put(RPU_CR_REGION, RPU_OP2_DATA, 4'h2, 32'h0000_3017);
        put(RPU_CR_REGION, RPU_OP2_DATA, 4'h1, 32'h0000_001b);
        put(RPU_CR_PERM, RPU_OP2_DATA, 4'h0, 32'h0000_0024);
        put(RPU_CR_CTRL, RPU_OP2_DATA, 4'h0, 32'h1);
        acc_chk(32'h3010, 1'b0, 32'h3010, 1'b1, 1'b1);
        acc_chk(32'h3010, 1'b1, 32'h3010, 1'b1, 1'b0);
        acc_chk(32'h2010, 1'b0, 32'h2010, 1'b0, 1'b1);
        $display("test overlap done");
        for (int k = 0; k < 6; k++)
        begin
            put(RPU_CR_CTRL, RPU_OP2_DATA, 4'h0, 32'h0);
            for (int n = 0; n < RPU_NREG; n++)
            begin
                v = u_core.legal_region($random(seed));
                put(RPU_CR_REGION, RPU_OP2_DATA, n[3:0], (n == 0 && k[0]) ? 32'h3f : v);
                put(RPU_CR_REGION, RPU_OP2_INST, n[3:0], v);
                get_chk(RPU_CR_REGION, RPU_OP2_INST, n[3:0], m_reg[1][n]);
                get_chk(RPU_CR_REGION, RPU_OP2_DATA, n[3:0], m_reg[0][n]);
            end
            for (int p = 0; p < 2; p++)
            begin
                v = $random(seed);
                put(RPU_CR_PERM, p[2:0], 4'h0, {16'h0, v[15:0]});
                put(RPU_CR_CACHE, p[2:0], 4'h0, {24'h0, v[23:16]});
                get_chk(RPU_CR_PERM, p[2:0], 4'h0, {16'h0, m_perm[p]});
                get_chk(RPU_CR_CACHE, p[2:0], 4'h0, {24'h0, m_cach[p]});
            end
            put(RPU_CR_BUFF, RPU_OP2_DATA, 4'h0, {24'h0, v[31:24]});
            get_chk(RPU_CR_BUFF, RPU_OP2_DATA, 4'h0, {24'h0, m_buff});
            put(RPU_CR_CTRL, RPU_OP2_DATA, 4'h0, 32'h1);
            get_chk(RPU_CR_CTRL, RPU_OP2_DATA, 4'h0, 32'h1);
            repeat (40) acc_rand;
        end
        // last pass left data region 0 as a full background; open every data area
        put(RPU_CR_PERM, RPU_OP2_DATA, 4'h0, 32'h0000_ffff);
        repeat (10) acc_rand;
        $display("test random_regions done");
        put(RPU_CR_CTRL, RPU_OP2_DATA, 4'h0, 32'h0);
        repeat (20) acc_rand;
        $display("test disabled done");
        finish_test;
    end
endmodule
